/* dv/test_toner_density_supply_control.sv */
`include "toner_map.svh"
module test_toner_density_supply_control
  import toner_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, wr_en, rd_en, copy_start, init_sample, id_sample, max_emitter_drive;
  logic power_on_warmup, lowpower_warmup, new_photoconductor_unit, trim_mode, clr;
  logic motor_on, service_call_error, irq;
  logic [3:0] addr;
  logic [15:0] wr_data, rd_data, on_cnt, rv;
  logic [12:0] density_reading, set_mv, surface_reading, pattern_reading;
  logic [7:0] fusing_temp, sensor_adjust;
  logic [2:0] supply_level;
  int failures, checks;
  localparam int ex_mv[5] = '{25, 50, 100, 200, 320};
  localparam int fx_ctrl[4] = '{3, 6, 30, 6};
  localparam int fx_mv[4] = '{2410, 2430, 2430, 2400};
  localparam int fx_ms[4] = '{200, 400, 0, 0};

  toner_density_supply_control #(.CYC_PER_MS(4)) i_dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .copy_start(copy_start), .density_reading(density_reading),
    .init_sample(init_sample), .id_sample(id_sample), .surface_reading(surface_reading),
    .pattern_reading(pattern_reading), .max_emitter_drive(max_emitter_drive),
    .power_on_warmup(power_on_warmup), .lowpower_warmup(lowpower_warmup), .fusing_temp(fusing_temp),
    .new_photoconductor_unit(new_photoconductor_unit), .motor_on(motor_on),
    .sensor_adjust(sensor_adjust), .supply_level(supply_level),
    .service_call_error(service_call_error), .irq(irq)
  );
  toner_partner i_partner (
    .clk(clk), .nrst(nrst), .sensor_adjust(sensor_adjust), .motor_on(motor_on),
    .trim_mode(trim_mode), .set_mv(set_mv), .clr(clr), .density_reading(density_reading),
    .on_cnt(on_cnt)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // Register bus cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input string name, input logic [15:0] exp);
    rd(a);
    chk(name, exp, rv);
  endtask : rchk

  // One copy with the given sensor level; returns once the decision is out
  task automatic copy(input logic [12:0] mv);
    @(posedge clk);
    set_mv <= mv;
    copy_start <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    copy_start <= 1'b0;
    clr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : copy

  // Copy, then judge level and motor run length in ms (one ms is 4 cycles here)
  task automatic run(input logic [12:0] mv, input logic [2:0] lvl, input int ms, input string name);
    int n;
    copy(mv);
    chk({name, " level"}, lvl, supply_level);
    n = 0;
    while (motor_on !== 1'b0 && n < ms * 4 + 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (4) @(posedge clk);
    chk({name, " on"}, 1, on_cnt >= ms * 4 && on_cnt <= ms * 4 + 8);
  endtask : run

  task automatic t_reset;
    chk("adjust", 8'h80, sensor_adjust);
    rchk(`A_CTRL, "ctrl", 16'h0000);
    rchk(`A_STEP, "step", 16'h0190);
    rchk(`A_LONG, "long", 16'h001E);
    rchk(`A_TARGET, "target", 16'h0960);
    rchk(`A_STDREF, "stdref", 16'h0960);
    rchk(4'hF, "unmapped", 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_init;
    wr(`A_TARGET, 16'h096A);
    trim_mode <= 1'b1;
    wr(`A_INIT, 16'h0001);
    repeat (20) begin
      @(posedge clk);
      init_sample <= 1'b1;
      @(posedge clk);
      init_sample <= 1'b0;
      repeat (2) @(posedge clk);
    end
    rd(`A_STATUS);
    chk("init busy", 0, rv[`ST_INIT]);
    rchk(`A_STDREF, "stdref", 16'h096A);
    chk("adjust", 8'h85, sensor_adjust);
    rd(`A_ISTAT);
    chk("init event", 1, rv[`EV_INIT]);
    wr(`A_ISTAT, 16'h0010);
    rd(`A_ISTAT);
    chk("init cleared", 0, rv[`EV_INIT]);
    trim_mode <= 1'b0;
    $display("test init done");
  endtask : t_init

  task automatic t_sens;
    wr(`A_STEP, 16'h000A);
    wr(`A_CTRL, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      run(13'(2410 + ex_mv[i]), 3'(i + 1), 10 << i, "sens1");
    end
    run(13'h096A, 3'h0, 0, "equal");
    wr(`A_LONG, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      copy(13'(2770 + 40 * i));
      chk("long level", 6 + i, supply_level);
      repeat (13000) @(posedge clk);
      chk("long on", 1, on_cnt >= 4000 && on_cnt <= 4008);
    end
    $display("test sensor done");
  endtask : t_sens

  task automatic t_fixed;
    for (int i = 0; i < 4; i++) begin
      wr(`A_CTRL, 16'(fx_ctrl[i]));
      run(13'(fx_mv[i]), 3'h0, fx_ms[i], "fixed");
    end
    wr(`A_CTRL, 16'h001B);
    copy(13'h096A);
    repeat (100) @(posedge clk);
    chk("fixed continuous", 1, motor_on);
    wr(`A_CTRL, 16'h001F);
    copy(13'h096A);
    chk("fixed none", 0, motor_on);
    $display("test fixed done");
  endtask : t_fixed

  task automatic id_pulse(input logic [12:0] sg);
    @(posedge clk);
    surface_reading <= sg;
    pattern_reading <= 13'h012C;
    id_sample <= 1'b1;
    @(posedge clk);
    id_sample <= 1'b0;
  endtask : id_pulse

  task automatic t_id;
    wr(`A_CTRL, 16'h0000);
    id_pulse(13'h09C4);
    rd(`A_STATUS);
    chk("id outside warmup", 0, rv[`ST_ID]);
    power_on_warmup <= 1'b1;
    id_pulse(13'h09C4);
    rd(`A_STATUS);
    chk("id fault", 1, rv[`ST_ID]);
    rchk(`A_ADAREF, "forced ref", 16'h09C4);
    chk("no sc", 0, service_call_error);
    run(13'h09D8, 3'h1, 10, "id ref");
    wr(`A_CTRL, 16'h0001);
    run(13'h097E, 3'h1, 10, "sens2");
    wr(`A_CTRL, 16'h0000);
    id_pulse(13'h0FA0);
    rd(`A_STATUS);
    chk("ada valid", 1, rv[`ST_AOK]);
    rchk(`A_ADAREF, "ada ref", 16'h0979);
    run(13'h0988, 3'h1, 10, "ada used");
    power_on_warmup <= 1'b0;
    $display("test id done");
  endtask : t_id

  task automatic t_pcu;
    @(posedge clk);
    new_photoconductor_unit <= 1'b1;
    @(posedge clk);
    new_photoconductor_unit <= 1'b0;
    run(13'h0988, 3'h2, 20, "pcu");
    $display("test pcu done");
  endtask : t_pcu

  task automatic t_td;
    wr(`A_IMASK, 16'h0008);
    run(13'h11F8, 3'h0, 200, "td");
    repeat (8) copy(13'h11F8);
    chk("sc early", 0, service_call_error);
    chk("irq early", 0, irq);
    copy(13'h11F8);
    repeat (2) @(posedge clk);
    chk("sc", 1, service_call_error);
    chk("irq", 1, irq);
    wr(`A_ISTAT, 16'h0008);
    repeat (3) @(posedge clk);
    chk("irq cleared", 0, irq);
    $display("test td done");
  endtask : t_td

  // Watchdog well beyond the expected run length
  initial begin
    #3ms;
    failures++;
    summarize();
  end

  initial begin
    {nrst, wr_en, rd_en, copy_start, init_sample, id_sample, max_emitter_drive} = '0;
    {power_on_warmup, lowpower_warmup, new_photoconductor_unit, trim_mode, clr} = '0;
    addr = 4'h0;
    wr_data = 16'h0000;
    set_mv = 13'h0960;
    surface_reading = 13'h0FA0;
    pattern_reading = 13'h012C;
    fusing_temp = 8'h19;
    failures = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_init();
    t_sens();
    t_fixed();
    t_id();
    t_pcu();
    t_td();
    summarize();
  end
endmodule : test_toner_density_supply_control

/* dv/toner_partner.sv */
// Density sensor and supply motor stand-in
module toner_partner (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sensor_adjust,
  input wire logic motor_on,
  input wire logic trim_mode,
  input wire logic [12:0] set_mv,
  input wire logic clr,
  output logic [12:0] density_reading,
  output logic [15:0] on_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sensor output follows the trim, 2 mV a step, while trimming; else the set level
  assign density_reading = trim_mode ? 13'(13'h0960 + 2 * (int'(sensor_adjust) - 128)) : set_mv;
  // Motor run time in clock cycles since the last clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      on_cnt <= 16'h0000;
    end else if (clr) begin
      on_cnt <= 16'h0000;
    end else if (motor_on) begin
      on_cnt <= on_cnt + 16'h0001;
    end
  end
endmodule : toner_partner

/* rtl/toner_density_supply_control.sv */
// Summary of operation
// - Four supply modes by code: sensor one (default), sensor two, fixed one, fixed two.
// - Sensor one supplies when reading exceeds active reference; adaptive reference kept.
// - Standard reference after new photoconductor unit until adaptive one is produced.
// - Sensor two behaves like sensor one but always uses standard reference.
// - Fixed two supplies every page for fixed on-time, no decision, no end level.
// - Initial setting trims sensor until reading equals target, stores standard reference.
// - One density sample per copy, compared with the active reference.
// - Reflectance readings accepted only in power-on or cool low-power warm-up.
// - Adaptive reference from reflectance ratio and reference minus reading.
// - Fixed on-time code: t,2t,4t,8t,12t,16t,continuous,none; t is 200 ms.
// - Sensor modes: excess up to S/16..4S/5 gives levels one to five, one to 16 base steps.
// - Excess above 4S/5 and below S is level six, at S level seven; long supply.
// - Base step default 0.4 s, long period default 30 s, both settable.
// - Long supply runs one second on, two off, until period ends.
// - Image-density readings abnormal on five voltage conditions.
// - Image-density fault forces adaptive reference to 2.5 V, no service error.
// - Density sensor fault gives fixed 200 ms supply per page.
// - Ten consecutive density sensor faults latch the service call error.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`include "toner_map.svh"

module toner_density_supply_control
  import toner_pkg::*;
#(
  parameter int CYC_PER_MS = `MS_NS / `CLK_NS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic copy_start,
  input wire logic [12:0] density_reading,
  input wire logic init_sample,
  input wire logic id_sample,
  input wire logic [12:0] surface_reading,
  input wire logic [12:0] pattern_reading,
  input wire logic max_emitter_drive,
  input wire logic power_on_warmup,
  input wire logic lowpower_warmup,
  input wire logic [7:0] fusing_temp,
  input wire logic new_photoconductor_unit,
  output logic motor_on,
  output logic [7:0] sensor_adjust,
  output logic [2:0] supply_level,
  output logic service_call_error,
  output logic irq
);

  st_t st_q;
  st_t st_d;
  logic cp_c;
  logic tdf_c;
  logic idok_c;
  logic idbad_c;
  logic gt_c;
  logic [12:0] ref_c;
  logic [12:0] ex_c;

  // Multiplier of the base time for an on-time code
  function automatic logic [4:0] mult_of(input logic [2:0] c);
    case (c)
      3'h0: mult_of = 5'h01;
      3'h1: mult_of = 5'h02;
      3'h2: mult_of = 5'h04;
      3'h3: mult_of = 5'h08;
      3'h4: mult_of = 5'h0C;
      3'h5: mult_of = 5'h10;
      default: mult_of = 5'h00;
    endcase
  endfunction : mult_of

  // Supply level from the excess of reading over reference
  function automatic logic [2:0] lvl_of(input logic [12:0] e);
    if (e >= `SENS_S) begin
      lvl_of = 3'h7;
    end else if (e <= `S_16) begin
      lvl_of = 3'h1;
    end else if (e <= `S_8) begin
      lvl_of = 3'h2;
    end else if (e <= `S_4) begin
      lvl_of = 3'h3;
    end else if (e <= `S_2) begin
      lvl_of = 3'h4;
    end else if (e <= `S_45) begin
      lvl_of = 3'h5;
    end else if (e >= `S_NEAR) begin
      lvl_of = 3'h6;
    end else begin
      lvl_of = 3'h0;
    end
  endfunction : lvl_of

  // Decision terms shared by the next-state logic and the checks
  always_comb begin
    cp_c = copy_start && (st_q.fsm == F_RUN);
    tdf_c = (density_reading >= `V_TD_HI) || (density_reading <= `V_TD_LO);
    if (st_q.mode == M_SENS2) begin
      ref_c = st_q.std_ref;
    end else if (st_q.ada_ok || st_q.id_bad) begin
      ref_c = st_q.ada_ref;
    end else begin
      ref_c = st_q.std_ref;
    end
    gt_c = density_reading > ref_c;
    ex_c = gt_c ? (density_reading - ref_c) : 13'h0000;
    idok_c = id_sample && (power_on_warmup || (lowpower_warmup && (fusing_temp <= st_q.tlim)));
    idbad_c = (surface_reading <= `V_SG_MIN)
      || (max_emitter_drive && (surface_reading < `V_SG_FULL))
      || (pattern_reading >= `V_SP_MAX)
      || ({1'b0, surface_reading} < ({1'b0, pattern_reading} + {1'b0, `V_DIFF_MIN}))
      || tdf_c;
  end

  // Next state
  always_comb begin
    logic [4:0] ev;
    logic [4:0] clr;
    logic [12:0] cur;
    logic signed [14:0] a;
    ev = 5'h00;
    clr = 5'h00;
    cur = 13'h0000;
    a = 15'sh0000;
    st_d = st_q;
    st_d.rd = 16'h0000;
    st_d.ms_tick = 1'b0;

    // Millisecond enable divider
    if (st_q.div == 15'(CYC_PER_MS - 1)) begin
      st_d.div = 15'h0000;
      st_d.ms_tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 15'h0001;
    end

    // Supply timers
    if (st_q.ms_tick) begin
      if (st_q.run_ms != 20'h00000) begin
        st_d.run_ms = st_q.run_ms - 20'h00001;
      end
      if (st_q.long_ms != 20'h00000) begin
        st_d.long_ms = st_q.long_ms - 20'h00001;
        if (st_q.phase == `CYCLE_MS - 12'h001) begin
          st_d.phase = 12'h000;
        end else begin
          st_d.phase = st_q.phase + 12'h001;
        end
      end
    end

    // Register writes
    if (wr_en) begin
      case (addr)
        `A_CTRL: begin
          st_d.mode = mode_t'(wr_data[`CTRL_MODE_LSB +: 2]);
          st_d.fcode = wr_data[`CTRL_FCODE_LSB +: 3];
        end
        `A_STEP: st_d.step_ms = wr_data;
        `A_LONG: st_d.long_s = wr_data[7:0];
        `A_TARGET: st_d.target = wr_data[12:0];
        `A_TLIM: st_d.tlim = wr_data[7:0];
        `A_ISTAT: clr = wr_data[4:0];
        `A_IMASK: st_d.mask = wr_data[4:0];
        `A_INIT: begin
          if (wr_data[0]) begin
            st_d.fsm = F_INIT;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, data stands one cycle
    if (rd_en) begin
      case (addr)
        `A_CTRL: st_d.rd = {11'h000, st_q.fcode, st_q.mode};
        `A_STEP: st_d.rd = st_q.step_ms;
        `A_LONG: st_d.rd = {8'h00, st_q.long_s};
        `A_TARGET: st_d.rd = {3'h0, st_q.target};
        `A_TLIM: st_d.rd = {8'h00, st_q.tlim};
        `A_STATUS: st_d.rd = {7'h00, st_q.fsm == F_INIT, st_q.ada_ok, st_q.id_bad,
          st_q.td_bad, st_q.sc, st_q.motor, st_q.level};
        `A_STDREF: st_d.rd = {3'h0, st_q.std_ref};
        `A_ADAREF: st_d.rd = {3'h0, st_q.ada_ref};
        `A_ISTAT: st_d.rd = {11'h000, st_q.stat};
        `A_IMASK: st_d.rd = {11'h000, st_q.mask};
        default: st_d.rd = 16'h0000;
      endcase
    end

    // Sensor initial setting
    case (st_q.fsm)
      F_RUN: begin
      end
      F_INIT: begin
        if (init_sample) begin
          if (density_reading < st_q.target) begin
            st_d.adj = (st_q.adj == 8'hFF) ? st_q.adj : st_q.adj + 8'h01;
          end else if (density_reading > st_q.target) begin
            st_d.adj = (st_q.adj == 8'h00) ? st_q.adj : st_q.adj - 8'h01;
          end else begin
            st_d.std_ref = density_reading;
            st_d.fsm = F_RUN;
            ev[`EV_INIT] = 1'b1;
          end
        end
      end
      default: st_d.fsm = F_RUN;
    endcase

    // Per-copy density decision
    if (cp_c) begin
      st_d.run_ms = 20'h00000;
      st_d.cont = 1'b0;
      st_d.level = 3'h0;
      // Restart the ms divider so a counted run lasts its full time; copies come far apart
      st_d.div = 15'h0000;
      st_d.ms_tick = 1'b0;
      if (tdf_c) begin
        st_d.td_bad = 1'b1;
        st_d.run_ms = `T_FIX_MS;
        ev[`EV_TD] = 1'b1;
        if (st_q.err_cnt != `ERR_LIMIT) begin
          st_d.err_cnt = st_q.err_cnt + 4'h1;
        end
        if (st_q.err_cnt == `ERR_LIMIT - 4'h1) begin
          st_d.sc = 1'b1;
          ev[`EV_SC] = 1'b1;
        end
      end else begin
        st_d.td_bad = 1'b0;
        st_d.err_cnt = 4'h0;
        if ((st_q.mode == M_FIX2) || ((st_q.mode == M_FIX1) && gt_c)) begin
          ev[`EV_SUPPLY] = 1'b1;
          st_d.cont = st_q.fcode == 3'h6;
          st_d.run_ms = 20'(mult_of(st_q.fcode)) * `T_FIX_MS;
        end else if (gt_c && (st_q.mode != M_FIX1)) begin
          ev[`EV_SUPPLY] = 1'b1;
          st_d.level = lvl_of(ex_c);
          if (lvl_of(ex_c) >= 3'h6) begin
            if (st_d.long_ms == 20'h00000) begin
              st_d.long_ms = 20'(st_q.long_s) * `MS_PER_S;
              st_d.phase = 12'h000;
            end
          end else if (lvl_of(ex_c) == 3'h5) begin
            st_d.run_ms = 20'(mult_of(3'h5)) * 20'(st_q.step_ms);
          end else begin
            st_d.run_ms = 20'(mult_of(lvl_of(ex_c) - 3'h1)) * 20'(st_q.step_ms);
          end
        end
      end
    end

    // Reflectance readings and adaptive reference
    if (idok_c) begin
      if (idbad_c) begin
        st_d.ada_ref = `V_FORCED;
        st_d.id_bad = 1'b1;
        ev[`EV_ID] = 1'b1;
      end else begin
        cur = st_q.ada_ok ? st_q.ada_ref : st_q.std_ref;
        a = $signed({2'b00, cur})
          + (($signed({2'b00, cur}) - $signed({2'b00, density_reading})) >>> 1);
        if ({2'b00, pattern_reading, 3'h0} < {5'h00, surface_reading}) begin
          a = a + $signed(`ADAPT_STEP);
        end else begin
          a = a - $signed(`ADAPT_STEP);
        end
        if (a < 15'sh0000) begin
          st_d.ada_ref = 13'h0000;
        end else if (a > $signed({2'b00, `V_FULL})) begin
          st_d.ada_ref = `V_FULL;
        end else begin
          st_d.ada_ref = a[12:0];
        end
        st_d.ada_ok = 1'b1;
        st_d.id_bad = 1'b0;
      end
    end
    if (new_photoconductor_unit) begin
      st_d.ada_ok = 1'b0;
      st_d.id_bad = 1'b0;
    end

    // Motor drive: counted run, continuous, or one-third duty long period
    st_d.motor = st_d.cont || (st_d.run_ms != 20'h00000)
      || ((st_d.long_ms != 20'h00000) && (st_d.phase < `ON_MS));

    // Sticky status, a new event wins over its clear
    st_d.stat = (st_q.stat & ~clr) | ev;
    st_d.irq = |(st_d.stat & st_d.mask);
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{mode: M_SENS1, fcode: 3'h0, step_ms: `RST_STEP_MS, long_s: `RST_LONG_S,
        target: `RST_TARGET, tlim: `RST_TLIM, std_ref: `RST_TARGET, ada_ref: `V_FORCED,
        adj: `RST_ADJ, fsm: F_RUN, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign rd_data = st_q.rd;
  assign motor_on = st_q.motor;
  assign sensor_adjust = st_q.adj;
  assign supply_level = st_q.level;
  assign service_call_error = st_q.sc;
  assign irq = st_q.irq;

  // Checks
  a_sc_tenth: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && tdf_c && (st_q.err_cnt == 4'h9) |=> service_call_error)
    else $error("service error not raised on tenth fault");
  a_sc_latched: assert property (@(posedge clk) disable iff (!nrst)
    service_call_error |=> service_call_error [*8])
    else $error("service error dropped");
  a_td_fallback: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && tdf_c |=> (st_q.run_ms == 20'h000C8) && (supply_level == 3'h0))
    else $error("density fault on-time wrong");
  a_id_force: assert property (@(posedge clk) disable iff (!nrst)
    idok_c && idbad_c && !new_photoconductor_unit && !(cp_c && tdf_c)
    |=> (st_q.ada_ref == 13'h09C4) && $stable(service_call_error) && st_q.id_bad)
    else $error("adaptive reference not forced");
  a_id_window: assert property (@(posedge clk) disable iff (!nrst)
    id_sample && !power_on_warmup && !lowpower_warmup |=> $stable(st_q.ada_ref))
    else $error("reflectance taken outside warm-up");
  a_sens2_ref: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.mode == M_SENS2) |-> (ref_c == st_q.std_ref))
    else $error("sensor two used adaptive reference");
  a_level_seven: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && !tdf_c && (st_q.mode != M_FIX1) && (st_q.mode != M_FIX2) && (ex_c >= 13'h0190)
    |=> (supply_level == 3'h7) && (st_q.long_ms != 20'h00000))
    else $error("level seven not taken");
  a_no_supply: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && !tdf_c && (st_q.mode != M_FIX2) && !gt_c && (st_q.long_ms == 20'h00000)
    |=> !motor_on)
    else $error("supply without excess");
  a_long_duty: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.long_ms != 20'h00000) && (st_q.phase >= 12'h3E8) && !st_q.cont
    && (st_q.run_ms == 20'h00000) |-> !motor_on)
    else $error("motor on in off phase");
  a_level_one: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && !tdf_c && (st_q.mode == M_SENS1) && gt_c && (ex_c <= 13'h0019)
    |=> (supply_level == 3'h1) && (st_q.run_ms == 20'($past(st_q.step_ms))))
    else $error("level one on-time wrong");
  a_fix_every: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && !tdf_c && (st_q.mode == M_FIX2) && (st_q.fcode == 3'h0)
    |=> (st_q.run_ms == 20'h000C8) && motor_on && (supply_level == 3'h0))
    else $error("fixed two page supply wrong");
  a_cont_run: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && !tdf_c && (st_q.mode == M_FIX2) && (st_q.fcode == 3'h6) |=> motor_on && st_q.cont)
    else $error("continuous code did not hold motor");
  a_none_code: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && !tdf_c && (st_q.mode == M_FIX2) && (st_q.fcode == 3'h7)
    && (st_q.long_ms == 20'h00000) |=> !motor_on)
    else $error("no-supply code drove motor");
  a_init_store: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.fsm == F_INIT) && init_sample && (density_reading == st_q.target)
    |=> (st_q.std_ref == $past(density_reading)) && (st_q.fsm == F_RUN))
    else $error("standard reference not stored");
  a_adj_track: assert property (@(posedge clk) disable iff (!nrst)
    (st_q.fsm == F_INIT) && init_sample && (density_reading < st_q.target) && (st_q.adj != 8'hFF)
    |=> (sensor_adjust == $past(sensor_adjust) + 8'h01))
    else $error("sensor trim did not step up");
  a_err_clear: assert property (@(posedge clk) disable iff (!nrst)
    cp_c && !tdf_c |=> (st_q.err_cnt == 4'h0) && !st_q.td_bad)
    else $error("fault count not cleared by good reading");

endmodule : toner_density_supply_control

/* rtl/toner_map.svh */
`ifndef TONER_MAP_SVH
`define TONER_MAP_SVH
// Register word offsets on the 4-bit address port
`define A_CTRL 4'h0
`define A_STEP 4'h1
`define A_LONG 4'h2
`define A_TARGET 4'h3
`define A_TLIM 4'h4
`define A_STATUS 4'h5
`define A_STDREF 4'h6
`define A_ADAREF 4'h7
`define A_ISTAT 4'h8
`define A_IMASK 4'h9
`define A_INIT 4'hA
// Control field positions
`define CTRL_MODE_LSB 0
`define CTRL_FCODE_LSB 2
// Status field positions
`define ST_MOTOR 3
`define ST_SC 4
`define ST_TD 5
`define ST_ID 6
`define ST_AOK 7
`define ST_INIT 8
// Event bits of the sticky status
`define EV_SUPPLY 0
`define EV_TD 1
`define EV_ID 2
`define EV_SC 3
`define EV_INIT 4
// Reset values
`define RST_STEP_MS 16'h0190
`define RST_LONG_S 8'h1E
`define RST_TARGET 13'h0960
`define RST_TLIM 8'h1E
`define RST_ADJ 8'h80
// Voltages in millivolts
`define V_FORCED 13'h09C4
`define V_TD_HI 13'h1194
`define V_TD_LO 13'h00C8
`define V_SG_MIN 13'h09C4
`define V_SG_FULL 13'h0DAC
`define V_SP_MAX 13'h09C4
`define V_DIFF_MIN 13'h03E8
`define V_FULL 13'h1FFF
// Sensitivity S and its fractions, millivolts
`define SENS_S 13'h0190
`define S_16 13'h0019
`define S_8 13'h0032
`define S_4 13'h0064
`define S_2 13'h00C8
`define S_45 13'h0140
`define S_NEAR 13'h0064
`define ADAPT_STEP 15'h0019
// Timing
`define CLK_NS 32'h32
`define MS_NS 32'hF4240
`define T_FIX_MS 20'h000C8
`define MS_PER_S 20'h003E8
`define ON_MS 12'h3E8
`define CYCLE_MS 12'hBB8
`define ERR_LIMIT 4'hA
`endif

/* rtl/toner_pkg.sv */
package toner_pkg;
  typedef enum logic [1:0] {
    M_SENS1 = 2'b00,
    M_SENS2 = 2'b01,
    M_FIX1 = 2'b10,
    M_FIX2 = 2'b11
  } mode_t;
  typedef enum logic {
    F_RUN = 1'b0,
    F_INIT = 1'b1
  } fsm_t;
  typedef struct packed {
    mode_t mode;
    logic [2:0] fcode;
    logic [15:0] step_ms;
    logic [7:0] long_s;
    logic [12:0] target;
    logic [7:0] tlim;
    logic [12:0] std_ref;
    logic [12:0] ada_ref;
    logic ada_ok;
    logic id_bad;
    logic td_bad;
    logic [3:0] err_cnt;
    logic sc;
    logic [2:0] level;
    logic [19:0] run_ms;
    logic cont;
    logic [19:0] long_ms;
    logic [11:0] phase;
    logic [14:0] div;
    logic ms_tick;
    logic motor;
    logic [7:0] adj;
    fsm_t fsm;
    logic [4:0] stat;
    logic [4:0] mask;
    logic irq;
    logic [15:0] rd;
  } st_t;
endpackage : toner_pkg
